// [pkg/igs_map.vh]
// register map, field positions, reset values and counts of the gain block
`ifndef IGS_MAP_VH
`define IGS_MAP_VH
// ==========================================
// register byte addresses
`define IGS_CTRL_ADDR      12'h000
`define IGS_ATTEN_ADDR     12'h004
`define IGS_STATUS_ADDR    12'h008
`define IGS_LEFT_ADDR      12'h00C
`define IGS_RIGHT_ADDR     12'h010
// ==========================================
// control fields
`define IGS_FMT_BIT        0
`define IGS_POL_BIT        1
`define IGS_ATC_BIT        2
`define IGS_WL0_BIT        3
`define IGS_WL1_BIT        4
`define IGS_SCA_BIT        6
`define IGS_CTRL_MASK      7'h5F
`define IGS_CTRL_RESET     7'h00
// ==========================================
// attenuation fields
`define IGS_ATTEN_RESET    16'hFFFF
// ==========================================
// status fields
`define IGS_ST_ENC_BIT     0
`define IGS_ST_PEAK_BIT    1
`define IGS_ST_RSV_BIT     2
// ==========================================
// detection and modulator
`define IGS_SYNC_WORD      8'hA5
`define IGS_LOSS_SAMPLES   1024
`define IGS_MOD_DIV        16
`define IGS_MOD_LEVELS     8
`endif

// [hw/igs_core.v]
// serial input format, attenuation select, material detect and gain scaling
`timescale 1ns/100ps
`include "igs_map.vh"

module igs_core #(
  parameter LOSS_SAMPLES = `IGS_LOSS_SAMPLES,
  parameter MOD_DIV      = `IGS_MOD_DIV
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // apb slave
  input  wire [11:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // serial audio from the source
  input  wire        bitClockIn,
  input  wire        lrWordClockIn,
  input  wire        serialDataIn,
  // indicators
  output wire        encodedInd,
  output wire        peakInd,
  // attenuation and samples toward the filter
  output wire [7:0]  leftAttenEff,
  output wire [7:0]  rightAttenEff,
  output reg  [23:0] leftSample,
  output reg  [23:0] rightSample,
  output reg         sampleStrobe,
  // modulator codes
  output reg  [2:0]  leftModCode,
  output reg  [2:0]  rightModCode
);

  // ==========================================
  // helpers
  function [4:0] wordLen;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    wordLen = 5'd16;
        3'h2:    wordLen = 5'd20;
        3'h4:    wordLen = 5'd24;
        3'h6:    wordLen = 5'd24;
        3'h1:    wordLen = 5'd16;
        3'h3:    wordLen = 5'd24;
        default: wordLen = 5'd0;
      endcase
    end
  endfunction

  function [2:0] quant;
    input signed [31:0] v;
    reg signed [31:0] t;
    begin
      t = (v >>> 21) + 32'sh4;
      if (t < 0)
        quant = 3'h0;
      else if (t > 32'sh7)
        quant = 3'h7;
      else
        quant = t[2:0];
    end
  endfunction

  // ==========================================
  // apb registers
  reg  [6:0]  ctrl_q;
  reg  [15:0] atten_q;
  reg         encoded_q;
  reg         peak_q;
  wire        wrEn = psel & penable & pwrite;
  wire        hit  = (paddr == `IGS_CTRL_ADDR) | (paddr == `IGS_ATTEN_ADDR) |
                     (paddr == `IGS_STATUS_ADDR) | (paddr == `IGS_LEFT_ADDR) |
                     (paddr == `IGS_RIGHT_ADDR);
  wire        fmtI2s  = ctrl_q[`IGS_FMT_BIT];
  wire        polSwap = ctrl_q[`IGS_POL_BIT];
  wire        atcOn   = ctrl_q[`IGS_ATC_BIT];
  wire        scaAna  = ctrl_q[`IGS_SCA_BIT];
  wire [2:0]  fmtSel  = {ctrl_q[`IGS_WL1_BIT], ctrl_q[`IGS_WL0_BIT],
                         fmtI2s};
  wire [4:0]  wLen    = wordLen(fmtSel);
  wire        fmtRsv  = (wLen == 5'd0);
  wire        leftJust = (fmtSel == 3'h6);

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q  <= `IGS_CTRL_RESET;
      atten_q <= `IGS_ATTEN_RESET;
    end else if (wrEn) begin
      if (paddr == `IGS_CTRL_ADDR)
        ctrl_q <= pwdata[6:0] & `IGS_CTRL_MASK;
      if (paddr == `IGS_ATTEN_ADDR)
        atten_q <= pwdata[15:0];
    end
  end

  always @* begin
    prdata = 32'h00000000;
    if (psel & ~pwrite) begin
      case (paddr)
        `IGS_CTRL_ADDR:   prdata = {25'h0, ctrl_q};
        `IGS_ATTEN_ADDR:  prdata = {16'h0, atten_q};
        `IGS_STATUS_ADDR: prdata = {29'h0, fmtRsv, peak_q, encoded_q};
        `IGS_LEFT_ADDR:   prdata = {8'h00, leftSample};
        `IGS_RIGHT_ADDR:  prdata = {8'h00, rightSample};
        default:          prdata = 32'h00000000;
      endcase
    end
  end

  // common mode ignores the right level entirely
  assign leftAttenEff  = atten_q[7:0];
  assign rightAttenEff = atcOn ? atten_q[7:0] : atten_q[15:8];

  // ==========================================
  // pin synchronisers: bit clock, word clock, data
  reg  [2:0] sync1_q;
  reg  [2:0] sync2_q;
  reg  [2:0] sync3_q;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
    end else begin
      sync1_q <= {serialDataIn, lrWordClockIn, bitClockIn};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end
  // a level counts only once two stages agree; a split pair holds it
  reg  [2:0] pin_q;
  wire [2:0] pin_d = (sync2_q & sync3_q) | (pin_q & (sync2_q | sync3_q));
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      pin_q <= 3'h0;
    else
      pin_q <= pin_d;
  end
  wire bckRise = pin_d[0] & ~pin_q[0];
  wire lrLvl   = pin_d[1];
  wire datBit  = pin_d[2];

  // ==========================================
  // serial receiver
  reg  [31:0] shift_q;
  reg  [5:0]  cnt_q;
  reg         lrLast_q;
  reg  [23:0] word;
  reg  [31:0] raw;
  reg  [5:0]  need;
  wire        slotEnd = bckRise & (lrLvl != lrLast_q);
  // i2s ignores polarity and always has left on the low phase
  wire        slotLeft = fmtI2s ? ~lrLast_q :
                         (lrLast_q ^ polSwap);

  // right-justified takes the last bits, others count from the edge
  always @* begin
    need = {1'b0, wLen} + {5'h0, fmtI2s};
    raw  = 32'h00000000;
    if (fmtI2s | leftJust) begin
      if (cnt_q >= need)
        raw = shift_q >> (cnt_q - need);
      else
        raw = shift_q << (need - cnt_q);
    end else begin
      raw = shift_q;
    end
    case (wLen)
      5'd16:   word = {raw[15:0], 8'h00};
      5'd20:   word = {raw[19:0], 4'h0};
      default: word = raw[23:0];
    endcase
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      shift_q  <= 32'h00000000;
      cnt_q    <= 6'h00;
      lrLast_q <= 1'b0;
    end else if (bckRise) begin
      if (slotEnd) begin
        shift_q  <= {31'h0, datBit};
        cnt_q    <= 6'h01;
        lrLast_q <= lrLvl;
      end else begin
        shift_q <= {shift_q[30:0], datBit};
        if (cnt_q != 6'h3F)
          cnt_q <= cnt_q + 6'h01;
      end
    end
  end

  // ==========================================
  // material detection on the hidden bit of left words
  localparam LCW = 16;
  reg  [15:0]    hidden_q;
  reg  [LCW-1:0] loss_q;
  wire           takeWord = slotEnd & ~fmtRsv;
  wire [15:0]    hiddenNext = {hidden_q[14:0], raw[0]};

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hidden_q  <= 16'h0000;
      loss_q    <= {LCW{1'b0}};
      encoded_q <= 1'b0;
      peak_q    <= 1'b0;
    end else if (takeWord & slotLeft) begin
      hidden_q <= hiddenNext;
      if (hiddenNext[15:8] == `IGS_SYNC_WORD) begin
        encoded_q <= 1'b1;
        peak_q    <= hiddenNext[0];
        loss_q    <= {LCW{1'b0}};
      end else if (loss_q == LOSS_SAMPLES[LCW-1:0] - 1'b1) begin
        // long silence of the code falls back to standard material
        encoded_q <= 1'b0;
        peak_q    <= 1'b0;
        loss_q    <= {LCW{1'b0}};
      end else begin
        loss_q <= loss_q + 1'b1;
      end
    end
  end

  assign encodedInd = encoded_q;
  assign peakInd    = peak_q;

  // ==========================================
  // gain scaling and sample hand-off
  wire        digCut = ~scaAna & ~peak_q;
  wire [23:0] scaled = digCut ? {word[23], word[23:1]} : word;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      leftSample   <= 24'h000000;
      rightSample  <= 24'h000000;
      sampleStrobe <= 1'b0;
    end else begin
      sampleStrobe <= takeWord;
      if (takeWord) begin
        if (slotLeft)
          leftSample <= scaled;
        else
          rightSample <= scaled;
      end
    end
  end

  // ==========================================
  // oversampling modulator, one step per divider pulse
  localparam DW = 8;
  reg  [DW-1:0] div_q;
  wire          modEn = (div_q == MOD_DIV[DW-1:0] - 1'b1);
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      div_q <= {DW{1'b0}};
    else if (modEn)
      div_q <= {DW{1'b0}};
    else
      div_q <= div_q + 1'b1;
  end

  // integrators wrap on overload; inputs stay well inside full scale
  reg  signed [31:0] lInt_q [0:3];
  reg  signed [31:0] rInt_q [0:3];
  wire signed [31:0] lIn = {{8{leftSample[23]}}, leftSample};
  wire signed [31:0] rIn = {{8{rightSample[23]}}, rightSample};
  wire signed [31:0] lFb = ($signed({29'h0, leftModCode}) * 32'sh2
                            - 32'sh7) <<< 20;
  wire signed [31:0] rFb = ($signed({29'h0, rightModCode}) * 32'sh2
                            - 32'sh7) <<< 20;
  integer k;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (k = 0; k < 4; k = k + 1) begin
        lInt_q[k] <= 32'sh0;
        rInt_q[k] <= 32'sh0;
      end
      leftModCode  <= 3'h4;
      rightModCode <= 3'h4;
    end else if (modEn) begin
      lInt_q[0] <= lInt_q[0] + lIn - lFb;
      rInt_q[0] <= rInt_q[0] + rIn - rFb;
      for (k = 1; k < 4; k = k + 1) begin
        lInt_q[k] <= lInt_q[k] + lInt_q[k-1] - lFb;
        rInt_q[k] <= rInt_q[k] + rInt_q[k-1] - rFb;
      end
      leftModCode  <= quant(lInt_q[3]);
      rightModCode <= quant(rInt_q[3]);
    end
  end

endmodule

// [testbench/igs_core_assertions.sv]
// port checker of the gain block
`timescale 1ns/100ps
module igs_core_chk (
  // clock and reset
  input wire        core_clk,
  input wire        rstn,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] prdata,
  input wire        pslverr,
  // block outputs
  input wire        encodedInd,
  input wire        peakInd,
  input wire [7:0]  leftAttenEff,
  input wire [7:0]  rightAttenEff,
  input wire [23:0] leftSample,
  input wire        sampleStrobe,
  input wire [2:0]  leftModCode
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  // ==========================================
  // register bus
  err_in_access_a: assert property (pslverr |-> psel && penable)
    else $error("error flag outside access phase");
  rdata_idle_a: assert property ((!psel || pwrite) |-> prdata == 32'h0)
    else $error("read data outside a read");
  // ==========================================
  // attenuation, detection, samples, modulator
  atten_by_write_a: assert property (
    $changed({leftAttenEff, rightAttenEff}) |->
    $past(psel && penable && pwrite)) else $error("level moved unasked");
  peak_needs_enc_a: assert property (
    peakInd |-> encodedInd) else $error("peak without encoded");
  ind_at_word_a: assert property (
    $changed({encodedInd, peakInd}) |-> sampleStrobe ||
    $past(sampleStrobe) || $past(sampleStrobe, 2))
    else $error("indicator moved without a word");
  strobe_pulse_a: assert property (
    sampleStrobe |=> !sampleStrobe) else $error("strobe too long");
  sample_strobe_a: assert property (
    $changed(leftSample) |-> sampleStrobe)
    else $error("sample moved without strobe");
  mod_step_a: assert property (
    $changed(leftModCode) |=> $stable(leftModCode)[*8])
    else $error("modulator stepped too soon");
endmodule
bind igs_core igs_core_chk igs_core_chk_i (.core_clk, .rstn, .psel,
  .penable, .pwrite, .prdata, .pslverr, .encodedInd, .peakInd,
  .leftAttenEff, .rightAttenEff, .leftSample, .sampleStrobe,
  .leftModCode);

// [testbench/igs_src.sv]
// serial audio source model
`timescale 1ns/100ps
module igs_src (
  // serial audio toward the block
  output logic bitClockIn,
  output logic lrWordClockIn,
  output logic serialDataIn
);
  initial begin
    bitClockIn = 1'b0;
    lrWordClockIn = 1'b0;
    serialDataIn = 1'b0;
  end
  // one slot of 32 bits msb first; clock idles low between slots
  task automatic slot(input logic lvl, input logic [31:0] bits);
    lrWordClockIn = lvl;
    for (int i = 31; i >= 0; i--) begin
      serialDataIn = bits[i];
      #80 bitClockIn = 1'b1;
      #80 bitClockIn = 1'b0;
    end
    // released line must not look like held data
    serialDataIn = ~bits[0];
  endtask
endmodule

// [testbench/tb_igs_core.sv]
// self-checking bench of the gain block
`timescale 1ns/100ps
`include "igs_map.vh"
module tb_igs_core;
  typedef struct packed {
    logic [6:0]  ctrl;
    logic        lvl;
    logic        left;
    logic [23:0] exp;
  } igs_row_t;
  localparam logic [31:0] slotBits = 32'h81234567;
  localparam logic [15:0] hidBits  = 16'hA501;
  logic        core_clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic        bitClockIn, lrWordClockIn, serialDataIn, sampleStrobe;
  logic        encodedInd, peakInd, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  leftAttenEff, rightAttenEff;
  logic [23:0] leftSample, rightSample;
  logic [2:0]  leftModCode, rightModCode;
  int          compares, mismatches, strobes, n;
  igs_row_t    rows [10] = '{
    '{7'h40, 1'b1, 1'b1, 24'h456700}, '{7'h48, 1'b0, 1'b0, 24'h345670},
    '{7'h50, 1'b1, 1'b1, 24'h234567}, '{7'h58, 1'b0, 1'b0, 24'h812345},
    '{7'h41, 1'b0, 1'b1, 24'h024600}, '{7'h49, 1'b1, 1'b0, 24'h02468A},
    '{7'h42, 1'b1, 1'b0, 24'h456700}, '{7'h43, 1'b0, 1'b1, 24'h024600},
    '{7'h00, 1'b1, 1'b1, 24'h22B380}, '{7'h18, 1'b1, 1'b1, 24'hC091A2}};
  igs_core #(.LOSS_SAMPLES(8)) igs_core_i (.core_clk, .rstn, .paddr,
    .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .bitClockIn, .lrWordClockIn, .serialDataIn, .encodedInd, .peakInd,
    .leftAttenEff, .rightAttenEff, .leftSample, .rightSample,
    .sampleStrobe, .leftModCode, .rightModCode);
  igs_src igs_src_i (.bitClockIn, .lrWordClockIn, .serialDataIn);
  // ==========================================
  // tasks
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================
  // clock, reset, watchdog
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (sampleStrobe === 1'b1) strobes++;
  initial begin
    #700000;
    mismatches++;
    end_of_test;
  end
  // ==========================================
  // main sequence
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    chk({16'h0, leftAttenEff, rightAttenEff}, 32'hFFFF);
    chk({26'h0, leftModCode, rightModCode}, 32'h24);
    chk({31'h0, pready}, 32'h1);
    apb(`IGS_CTRL_ADDR, 1'b0, 32'h0);
    chk(rd, 32'h0);
    apb(`IGS_ATTEN_ADDR, 1'b1, 32'h2211);
    chk({16'h0, rightAttenEff, leftAttenEff}, 32'h2211);
    apb(`IGS_CTRL_ADDR, 1'b1, 32'hFFFFFFFF);
    apb(`IGS_CTRL_ADDR, 1'b0, 32'h0);
    chk(rd, 32'h5F);
    chk({16'h0, rightAttenEff, leftAttenEff}, 32'h1111);
    apb(12'h020, 1'b0, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    for (int i = 0; i < 10; i++) begin
      apb(`IGS_CTRL_ADDR, 1'b1, {25'h0, rows[i].ctrl});
      igs_src_i.slot(~rows[i].lvl, slotBits);
      igs_src_i.slot(rows[i].lvl, slotBits);
      igs_src_i.slot(~rows[i].lvl, slotBits);
      chk({8'h0, rows[i].left ? leftSample : rightSample},
          {8'h0, rows[i].exp});
    end
    apb(`IGS_LEFT_ADDR, 1'b0, 32'h0);
    chk(rd, 32'h00C091A2);
    // reserved format takes nothing
    apb(`IGS_CTRL_ADDR, 1'b1, 32'h51);
    n = strobes;
    igs_src_i.slot(1'b1, slotBits);
    igs_src_i.slot(1'b0, slotBits);
    chk(32'(strobes - n), 32'h0);
    apb(`IGS_STATUS_ADDR, 1'b0, 32'h0);
    chk(rd, 32'h4);
    // hidden bits in left words, then loss of them
    apb(`IGS_CTRL_ADDR, 1'b1, 32'h40);
    for (int i = 15; i >= -9; i--) begin
      igs_src_i.slot(1'b1, {slotBits[31:1], i >= 0 ? hidBits[i] : 1'b1});
      igs_src_i.slot(1'b0, slotBits);
      if (i == 0) begin
        chk({30'h0, encodedInd, peakInd}, 32'h3);
        apb(`IGS_CTRL_ADDR, 1'b1, 32'h0);
      end
      if (i == -1)
        chk({8'h0, leftSample}, 32'h456700);
    end
    apb(`IGS_STATUS_ADDR, 1'b0, 32'h0);
    chk(rd, 32'h0);
    apb(`IGS_RIGHT_ADDR, 1'b0, 32'h0);
    chk(rd, 32'h0022B380);
    // mid-run reset: digital scaling and full levels come back
    apb(`IGS_CTRL_ADDR, 1'b1, 32'h44);
    apb(`IGS_ATTEN_ADDR, 1'b1, 32'h3322);
    chk({16'h0, rightAttenEff, leftAttenEff}, 32'h2222);
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    chk({16'h0, leftAttenEff, rightAttenEff}, 32'hFFFF);
    chk({26'h0, leftModCode, rightModCode}, 32'h24);
    apb(`IGS_CTRL_ADDR, 1'b0, 32'h0);
    chk(rd, 32'h0);
    end_of_test;
  end
endmodule
